/* hw/tssm_codeword_link.sv */
// Top: T1 codeword link with AXI4-Lite registers
//
// Overview of operation
// RL1: Reset bit restores all codeword registers
// RL2: Reset bit clears itself after acting
// RL3: Receive filter needs 1/3/5/7 identical words
// RL4: Separate match filter, two filters total
// RL5: Send bit starts transmission, then self-clears
// RL6: Received word in bits 5:0, upper zero
// RL7: Three expected values, one alarm each
// RL8: Match only after match filter qualifies
// RL9: Software loads word before requesting send
// RL10: Repeat count sets sends, resets to one
// RL11: Zero repeat count sends without end
// RL12: Nonzero count then resend ends continuous
// RL13: Idle flag after words, abort if enabled
// RL14: Reception only while receive enable set
// RL15: Codeword sent rightmost bit first
// RL16: Match filter bits 6:5 same encoding
// RL17: Frame is zero, six bits, zero, ones
// RL18: Different or errored word restarts counts
//
// Local design decision: the AXI4-Lite register port.
module tssm_codeword_link
	import tssm_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              s_axil_awvalid,
	output      logic              s_axil_awready,
	input  wire logic [ADDR_W-1:0] s_axil_awaddr,
	input  wire logic              s_axil_wvalid,
	output      logic              s_axil_wready,
	input  wire logic [31:0]       s_axil_wdata,
	input  wire logic [3:0]        s_axil_wstrb,
	output      logic              s_axil_bvalid,
	input  wire logic              s_axil_bready,
	output      logic [1:0]        s_axil_bresp,
	input  wire logic              s_axil_arvalid,
	output      logic              s_axil_arready,
	input  wire logic [ADDR_W-1:0] s_axil_araddr,
	output      logic              s_axil_rvalid,
	input  wire logic              s_axil_rready,
	output      logic [31:0]       s_axil_rdata,
	output      logic [1:0]        s_axil_rresp,
	input  wire logic              fdlTxSlot,
	output      logic              fdlTxBit,
	output      logic              fdlTxActive,
	input  wire logic              fdlRxSlot,
	input  wire logic              fdlRxBit,
	output      logic              rxCodewordAlarm,
	output      logic [2:0]        matchAlarm
);

	//----------------------------------------
	// Decode helpers
	//----------------------------------------
	function automatic logic [8:0] reg_index(input logic [ADDR_W-1:0] addr);
		reg_index = addr[10:2];
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		logic [8:0] idx;
		idx = addr[10:2];
		is_mapped = addr[1:0] == 2'h0 && addr[ADDR_W-1] == 1'b0 &&
			((idx >= IDX_CONTROL && idx <= IDX_STATUS) || idx == IDX_PART || idx == IDX_REVISION);
	endfunction

	tssm_ctrl_type     ctrlQ;
	tssm_status_type   statusQ;
	tssm_word_type     expectQ [3];
	tssm_word_type     txWordQ;
	tssm_word_type     rxWordQ;
	logic [7:0]        repeatQ;
	logic              awHeldQ;
	logic              wHeldQ;
	logic [ADDR_W-1:0] awAddrQ;
	logic [7:0]        wDataQ;
	logic              wLaneQ;
	logic              doWrite;
	logic              wrLane;
	logic [8:0]        wrIdx;
	logic              cwReset;
	logic              sendPulse;
	logic [31:0]       rdataD;

	//----------------------------------------
	// AXI4-Lite write channel
	//----------------------------------------
	assign s_axil_awready = !awHeldQ && !s_axil_bvalid;
	assign s_axil_wready  = !wHeldQ && !s_axil_bvalid;
	assign doWrite        = awHeldQ && wHeldQ;
	assign wrIdx          = reg_index(awAddrQ);
	assign wrLane         = doWrite && wLaneQ && is_mapped(awAddrQ);
	assign cwReset        = wrLane && wrIdx == IDX_CONTROL && wDataQ[3]; // RL1 RL2
	assign sendPulse      = wrLane && wrIdx == IDX_CONTROL && wDataQ[0] && !wDataQ[3]; // RL5

	always_ff @(posedge core_clk)
	begin
		if (rst || doWrite)
			awHeldQ <= 1'b0;
		else if (s_axil_awvalid && s_axil_awready)
			awHeldQ <= 1'b1;
		if (rst || doWrite)
			wHeldQ <= 1'b0;
		else if (s_axil_wvalid && s_axil_wready)
			wHeldQ <= 1'b1;
		if (s_axil_awvalid && s_axil_awready)
			awAddrQ <= s_axil_awaddr;
		if (s_axil_wvalid && s_axil_wready)
		begin
			wDataQ <= s_axil_wdata[7:0];
			wLaneQ <= s_axil_wstrb[0];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_axil_bvalid <= 1'b0;
			s_axil_bresp  <= RESP_OKAY;
		end
		else if (doWrite)
		begin
			s_axil_bvalid <= 1'b1;
			s_axil_bresp  <= is_mapped(awAddrQ) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axil_bready)
			s_axil_bvalid <= 1'b0;
	end

	//----------------------------------------
	// Software registers
	//----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst || cwReset) // RL1
		begin
			ctrlQ   <= tssm_ctrl_type'(CONTROL_RST);
			txWordQ <= WORD_RST;
			repeatQ <= REPEAT_RST; // RL10
		end
		else if (wrLane)
		begin
			if (wrIdx == IDX_CONTROL)
			begin
				ctrlQ                      <= tssm_ctrl_type'(wDataQ);
				ctrlQ.receiveCodewordReset <= 1'b0; // RL2
				ctrlQ.sendCodeword         <= 1'b0; // RL5
			end
			else if (wrIdx == IDX_TXWORD)
				txWordQ <= wDataQ[5:0];
			else if (wrIdx == IDX_REPEAT)
				repeatQ <= wDataQ;
		end
	end

	for (genvar i = 0; i < 3; i++)
	begin : g_expect
		always_ff @(posedge core_clk)
		begin
			if (rst || cwReset) // RL1
				expectQ[i] <= WORD_RST;
			else if (wrLane && wrIdx == IDX_EXPECT1 + 9'(i))
				expectQ[i] <= wDataQ[5:0]; // RL7
		end
	end

	//----------------------------------------
	// Receive deframer
	//----------------------------------------
	logic [15:0]   rxShiftQ;
	logic [15:0]   rxShiftD;
	logic [3:0]    rxCntQ;
	logic          rxLockQ;
	logic          frameOk;
	logic          rxEnable;
	logic          wordValidQ;
	logic          wordErrorQ;
	tssm_word_type wordValueQ;

	assign rxEnable = ctrlQ.receiveCodewordEnable; // RL14
	assign rxShiftD = {fdlRxBit, rxShiftQ[15:1]};
	assign frameOk  = rxShiftD[0] == 1'b0 && rxShiftD[7] == 1'b0 && rxShiftD[15:8] == CW_ONES; // RL17

	always_ff @(posedge core_clk)
	begin
		if (rst || cwReset || !rxEnable) // RL14
		begin
			rxShiftQ   <= 16'h0000;
			rxCntQ     <= 4'h0;
			rxLockQ    <= 1'b0;
			wordValidQ <= 1'b0;
			wordErrorQ <= 1'b0;
			wordValueQ <= WORD_RST;
		end
		else
		begin
			wordValidQ <= 1'b0;
			wordErrorQ <= 1'b0;
			if (fdlRxSlot)
			begin
				rxShiftQ <= rxShiftD;
				rxCntQ   <= rxCntQ + 4'h1;
				if ((!rxLockQ || rxCntQ == CW_LAST_BIT) && frameOk)
				begin
					rxLockQ    <= 1'b1;
					rxCntQ     <= 4'h0;
					wordValidQ <= 1'b1;
					wordValueQ <= rxShiftD[6:1];
				end
				else if (rxLockQ && rxCntQ == CW_LAST_BIT)
				begin
					rxLockQ    <= 1'b0;
					wordErrorQ <= 1'b1; // RL18
				end
			end
		end
	end

	//----------------------------------------
	// Two independent qualifiers
	//----------------------------------------
	logic          rxQual;
	logic          matchQual;
	tssm_word_type rxQualValue;
	tssm_word_type matchValue;

	tssm_qual_filter u_rx_filter ( // RL3 RL4
		.core_clk  (core_clk),
		.rst       (rst),
		.clear     (cwReset || !rxEnable),
		.filterSel (ctrlQ.receiveCodewordFilter),
		.wordValid (wordValidQ),
		.wordError (wordErrorQ),
		.wordValue (wordValueQ),
		.qualPulse (rxQual),
		.qualValue (rxQualValue)
	);

	tssm_qual_filter u_match_filter ( // RL4 RL16
		.core_clk  (core_clk),
		.rst       (rst),
		.clear     (cwReset || !rxEnable),
		.filterSel (ctrlQ.matchFilter),
		.wordValid (wordValidQ),
		.wordError (wordErrorQ),
		.wordValue (wordValueQ),
		.qualPulse (matchQual),
		.qualValue (matchValue)
	);

	always_ff @(posedge core_clk)
	begin
		if (rst || cwReset)
			rxWordQ <= WORD_RST; // RL1
		else if (rxQual)
			rxWordQ <= rxQualValue; // RL6
	end

	//----------------------------------------
	// Sticky status, write one to clear, set wins
	//----------------------------------------
	logic       matchHit [3];
	logic       stClear;
	logic       matchAlarmQ [3];
	logic       rxAlarmQ;

	assign stClear = wrLane && wrIdx == IDX_STATUS;

	for (genvar i = 0; i < 3; i++)
	begin : g_match
		assign matchHit[i] = matchQual && matchValue == expectQ[i]; // RL7 RL8
		always_ff @(posedge core_clk)
		begin
			if (rst || cwReset)
				matchAlarmQ[i] <= 1'b0;
			else if (matchHit[i])
				matchAlarmQ[i] <= 1'b1;
			else if (stClear && wDataQ[1 + i])
				matchAlarmQ[i] <= 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || cwReset)
			rxAlarmQ <= 1'b0;
		else if (rxQual)
			rxAlarmQ <= 1'b1; // RL3
		else if (stClear && wDataQ[0])
			rxAlarmQ <= 1'b0;
	end

	assign rxCodewordAlarm = rxAlarmQ;
	assign matchAlarm      = statusQ.matchAlarm;

	//----------------------------------------
	// Transmitter
	//----------------------------------------
	tssm_tx_state_type txStateQ;
	logic [15:0]       txShiftQ;
	logic [3:0]        txCntQ;
	logic [7:0]        txLeftQ;

	// One driver for the whole status word
	assign statusQ     = '{spare: 3'h0, txBusy: txStateQ != TX_IDLE,
		matchAlarm: {matchAlarmQ[2], matchAlarmQ[1], matchAlarmQ[0]}, rxAlarm: rxAlarmQ};
	assign fdlTxActive = statusQ.txBusy;

	always_ff @(posedge core_clk)
	begin
		if (rst || cwReset)
		begin
			txStateQ <= TX_IDLE;
			txShiftQ <= 16'hffff;
			txCntQ   <= 4'h0;
			txLeftQ  <= 8'h00;
		end
		else if (sendPulse) // RL5 RL12
		begin
			txStateQ <= TX_CODEWORD;
			txShiftQ <= build_frame(txWordQ); // RL17
			txCntQ   <= 4'h0;
			txLeftQ  <= repeatQ; // RL10
		end
		else if (fdlTxSlot)
		begin
			txShiftQ <= {1'b1, txShiftQ[15:1]}; // RL15
			txCntQ   <= txCntQ + 4'h1;
			case (txStateQ)
				TX_CODEWORD:
					if (txCntQ == CW_LAST_BIT)
					begin
						if (txLeftQ == 8'h01)
						begin
							txStateQ <= TX_CLOSE; // RL13
							txShiftQ <= {8'hff, ctrlQ.abortAfterMessage ? ABORT_SEQ : IDLE_FLAG};
							txCntQ   <= 4'h0;
						end
						else
						begin
							txShiftQ <= build_frame(txWordQ); // RL11
							if (txLeftQ != 8'h00)
								txLeftQ <= txLeftQ - 8'h01;
						end
					end
				TX_CLOSE:
					if (txCntQ == CLOSE_LAST_BIT)
						txStateQ <= TX_IDLE;
				default:
					txCntQ <= 4'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			fdlTxBit <= 1'b1;
		else if (fdlTxSlot)
			fdlTxBit <= statusQ.txBusy ? txShiftQ[0] : 1'b1; // RL15
	end

	//----------------------------------------
	// AXI4-Lite read channel
	//----------------------------------------
	logic [8:0] rdIdx;

	assign s_axil_arready = !s_axil_rvalid;
	assign rdIdx          = reg_index(s_axil_araddr);

	always_comb
	begin
		rdataD = 32'h0000_0000;
		if (rdIdx == IDX_CONTROL)
			rdataD[7:0] = ctrlQ; // RL2
		else if (rdIdx == IDX_RXWORD)
			rdataD[5:0] = rxWordQ; // RL6
		else if (rdIdx >= IDX_EXPECT1 && rdIdx <= IDX_EXPECT3)
			rdataD[5:0] = expectQ[rdIdx[1:0] - 2'h2];
		else if (rdIdx == IDX_TXWORD)
			rdataD[5:0] = txWordQ;
		else if (rdIdx == IDX_REPEAT)
			rdataD[7:0] = repeatQ;
		else if (rdIdx == IDX_STATUS)
			rdataD[7:0] = statusQ;
		else if (rdIdx == IDX_PART)
			rdataD[7:0] = PART_ID;
		else if (rdIdx == IDX_REVISION)
			rdataD[7:0] = REVISION_ID;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata  <= 32'h0000_0000;
			s_axil_rresp  <= RESP_OKAY;
		end
		else if (s_axil_arvalid && s_axil_arready)
		begin
			s_axil_rvalid <= 1'b1;
			s_axil_rdata  <= is_mapped(s_axil_araddr) ? rdataD : 32'h0000_0000;
			s_axil_rresp  <= is_mapped(s_axil_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axil_rready)
			s_axil_rvalid <= 1'b0;
	end

	//----------------------------------------
	// Assertions
	//----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_last_word(logic [7:0] left);
		txStateQ == TX_CODEWORD && fdlTxSlot && !sendPulse && !cwReset && txCntQ == CW_LAST_BIT && txLeftQ == left;
	endsequence

	a_reset_defaults: assert property (cwReset |=> repeatQ == REPEAT_RST && txWordQ == WORD_RST // RL1
		&& rxWordQ == WORD_RST && !fdlTxActive && matchAlarm == 3'h0)
		else $error("codeword reset left a register set");

	a_ctrl_selfclear: assert property (wrLane && wrIdx == IDX_CONTROL // RL2
		|=> !ctrlQ.receiveCodewordReset && !ctrlQ.sendCodeword)
		else $error("self-clearing bit read back as one");

	a_send_starts: assert property (sendPulse |=> txStateQ == TX_CODEWORD && txLeftQ == $past(repeatQ) // RL5
		&& txShiftQ == build_frame($past(txWordQ)))
		else $error("send did not load the codeword");

	a_rxword_upper: assert property (s_axil_arvalid && s_axil_arready && rdIdx == IDX_RXWORD // RL6
		|=> s_axil_rdata[31:6] == 26'h0 && s_axil_rdata[5:0] == rxWordQ)
		else $error("received word readback wrong");

	a_match_alarm: assert property (matchQual && matchValue == expectQ[0] && !cwReset |=> matchAlarm[0]) // RL7
		else $error("match alarm not raised");

	a_match_filtered: assert property ($rose(matchAlarm[2]) |-> $past(matchQual)) // RL8
		else $error("match alarm without qualified word");

	a_close_follows: assert property (s_last_word(8'h01) |=> txStateQ == TX_CLOSE // RL10 RL13
		&& txShiftQ[7:0] == ($past(ctrlQ.abortAfterMessage) ? ABORT_SEQ : IDLE_FLAG))
		else $error("closing sequence not started");

	a_endless_send: assert property (s_last_word(8'h00) |=> txStateQ == TX_CODEWORD && txLeftQ == 8'h00) // RL11
		else $error("continuous sending stopped");

	a_rx_disabled: assert property (!rxEnable |=> !wordValidQ ##1 !rxQual) // RL14
		else $error("word received while disabled");

	a_lsb_first: assert property (fdlTxSlot && fdlTxActive |=> fdlTxBit == $past(txShiftQ[0])) // RL15
		else $error("link bit order wrong");

endmodule // tssm_codeword_link

/* hw/tssm_pkg.sv */
// Package: register map, field layouts and types of the T1 codeword link
package tssm_pkg;

	//----------------------------------------
	// Register indices (byte address = 4 * index)
	//----------------------------------------
	localparam logic [8:0] IDX_CONTROL  = 9'h170;
	localparam logic [8:0] IDX_RXWORD   = 9'h171;
	localparam logic [8:0] IDX_EXPECT1  = 9'h172;
	localparam logic [8:0] IDX_EXPECT2  = 9'h173;
	localparam logic [8:0] IDX_EXPECT3  = 9'h174;
	localparam logic [8:0] IDX_TXWORD   = 9'h175;
	localparam logic [8:0] IDX_REPEAT   = 9'h176;
	localparam logic [8:0] IDX_STATUS   = 9'h177;
	localparam logic [8:0] IDX_PART     = 9'h1fe;
	localparam logic [8:0] IDX_REVISION = 9'h1ff;
	localparam int         ADDR_W       = 12;

	//----------------------------------------
	// Reset values and identity
	//----------------------------------------
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [5:0] WORD_RST    = 6'h00;
	localparam logic [7:0] REPEAT_RST  = 8'h01;
	localparam logic [7:0] PART_ID     = 8'h5a; // Arbitrary value
	localparam logic [7:0] REVISION_ID = 8'h03; // Arbitrary value

	//----------------------------------------
	// Link framing and bus answers
	//----------------------------------------
	localparam logic [3:0] CW_LAST_BIT    = 4'hf;
	localparam logic [3:0] CLOSE_LAST_BIT = 4'h7;
	localparam logic [7:0] CW_ONES        = 8'hff;
	localparam logic [7:0] IDLE_FLAG      = 8'h7e;
	localparam logic [7:0] ABORT_SEQ      = 8'hff;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	localparam logic [2:0] QUAL_NONE      = 3'h1;
	localparam logic [2:0] QUAL_THREE     = 3'h3;
	localparam logic [2:0] QUAL_FIVE      = 3'h5;
	localparam logic [2:0] QUAL_SEVEN     = 3'h7;

	//----------------------------------------
	// Types
	//----------------------------------------
	typedef logic [5:0] tssm_word_type;

	typedef struct packed {
		logic       abortAfterMessage;
		logic [1:0] matchFilter;
		logic       receiveCodewordEnable;
		logic       receiveCodewordReset;
		logic [1:0] receiveCodewordFilter;
		logic       sendCodeword;
	} tssm_ctrl_type;

	typedef struct packed {
		logic [2:0] spare;
		logic       txBusy;
		logic [2:0] matchAlarm;
		logic       rxAlarm;
	} tssm_status_type;

	typedef enum logic [1:0] {TX_IDLE, TX_CODEWORD, TX_CLOSE} tssm_tx_state_type;

	// Consecutive words needed for a filter setting
	function automatic logic [2:0] qual_need(input logic [1:0] sel);
		case (sel)
			2'h1:    qual_need = QUAL_THREE;
			2'h2:    qual_need = QUAL_FIVE;
			2'h3:    qual_need = QUAL_SEVEN;
			default: qual_need = QUAL_NONE;
		endcase
	endfunction

	// Sixteen link bits, bit 0 sent first
	function automatic logic [15:0] build_frame(input tssm_word_type cw);
		build_frame = {CW_ONES, 1'b0, cw, 1'b0};
	endfunction

endpackage

/* hw/tssm_qual_filter.sv */
// Consecutive identical codeword qualifier
module tssm_qual_filter
	import tssm_pkg::*;
(
	input  wire logic          core_clk,
	input  wire logic          rst,
	input  wire logic          clear,
	input  wire logic [1:0]    filterSel,
	input  wire logic          wordValid,
	input  wire logic          wordError,
	input  wire tssm_word_type wordValue,
	output      logic          qualPulse,
	output      tssm_word_type qualValue
);

	tssm_word_type lastQ;
	logic [2:0]    runQ;
	logic [2:0]    runD;
	logic [2:0]    need;

	assign need = qual_need(filterSel);

	always_comb
	begin
		if (runQ != 3'h0 && wordValue == lastQ)
			runD = (runQ == QUAL_SEVEN) ? runQ : runQ + 3'h1;
		else
			runD = 3'h1;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || clear)
		begin
			runQ  <= 3'h0;
			lastQ <= WORD_RST;
		end
		else if (wordError)
			runQ <= 3'h0; // RL18
		else if (wordValid)
		begin
			runQ  <= runD; // RL18
			lastQ <= wordValue;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || clear)
		begin
			qualPulse <= 1'b0;
			qualValue <= WORD_RST;
		end
		else
		begin
			qualPulse <= wordValid && !wordError && runD >= need; // RL3
			if (wordValid && !wordError)
				qualValue <= wordValue;
		end
	end

	//----------------------------------------
	// Assertions
	//----------------------------------------
	a_filter_none: assert property (@(posedge core_clk) disable iff (rst) // RL3
		wordValid && !wordError && !clear && filterSel == 2'h0 |=> qualPulse && qualValue == $past(wordValue))
		else $error("unfiltered word not passed");

	a_error_restart: assert property (@(posedge core_clk) disable iff (rst) // RL18
		wordError && !clear |=> runQ == 3'h0 && !qualPulse)
		else $error("count survived an errored word");

endmodule // tssm_qual_filter

/* sim/tssm_codeword_link_tb.sv */
// Self-checking bench of the codeword link
module tssm_codeword_link_tb
	import tssm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic core_clk, rst, awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
	logic [ADDR_W-1:0] awAddr, arAddr;
	logic [31:0]       wData, rData;
	logic [3:0]        wStrb;
	logic [1:0]        bResp, rResp;
	logic              fdlTxSlot, fdlTxBit, fdlTxActive, fdlRxSlot, fdlRxBit, rxCodewordAlarm;
	logic [2:0]        matchAlarm;
	logic              txHold, txFast, slotPrev;
	logic [33:0]       rdExp[$];
	logic              txExp[$];
	tssm_word_type     w;
	int                fails, checksDone, cycles;
	localparam logic [8:0] IDX_TAB [11] = '{IDX_CONTROL, IDX_RXWORD, IDX_EXPECT1, IDX_EXPECT2, IDX_EXPECT3,
		IDX_TXWORD, IDX_REPEAT, IDX_STATUS, IDX_PART, IDX_REVISION, 9'h100};
	localparam logic [7:0] RST_TAB [11] = '{CONTROL_RST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, REPEAT_RST, 8'h00,
		PART_ID, REVISION_ID, 8'h00};

	tssm_codeword_link i_dut (.core_clk(core_clk), .rst(rst), .s_axil_awvalid(awValid), .s_axil_awready(awReady),
		.s_axil_awaddr(awAddr), .s_axil_wvalid(wValid), .s_axil_wready(wReady), .s_axil_wdata(wData),
		.s_axil_wstrb(wStrb), .s_axil_bvalid(bValid), .s_axil_bready(bReady), .s_axil_bresp(bResp),
		.s_axil_arvalid(arValid), .s_axil_arready(arReady), .s_axil_araddr(arAddr), .s_axil_rvalid(rValid),
		.s_axil_rready(rReady), .s_axil_rdata(rData), .s_axil_rresp(rResp), .fdlTxSlot(fdlTxSlot),
		.fdlTxBit(fdlTxBit), .fdlTxActive(fdlTxActive), .fdlRxSlot(fdlRxSlot), .fdlRxBit(fdlRxBit),
		.rxCodewordAlarm(rxCodewordAlarm), .matchAlarm(matchAlarm));
	tssm_far_end i_far (.core_clk(core_clk), .rst(rst), .txHold(txHold), .txFast(txFast),
		.fdlTxActive(fdlTxActive), .fdlTxSlot(fdlTxSlot), .fdlRxSlot(fdlRxSlot), .fdlRxBit(fdlRxBit));

	always #25 core_clk = ~core_clk;

	//----------------------------------------
	// Checking and bus tasks
	//----------------------------------------
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		checksDone++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic test_done;
		if (fails == 0 && checksDone > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic axiWr(input logic [8:0] idx, input logic [7:0] v, input logic [1:0] er);
		logic       a, d, pa, pd;
		logic [1:0] r;
		@(posedge core_clk);
		awValid <= 1'b1;
		awAddr  <= {1'b0, idx, 2'b00};
		wValid  <= 1'b1;
		wData   <= {24'h0, v};
		bReady  <= 1'b1;
		pa = 1'b1;
		pd = 1'b1;
		while (pa || pd)
		begin
			@(negedge core_clk);
			a = pa && awReady;
			d = pd && wReady;
			@(posedge core_clk);
			if (a) awValid <= 1'b0;
			if (d) wValid <= 1'b0;
			pa = pa && !a;
			pd = pd && !d;
		end
		do @(negedge core_clk); while (bValid !== 1'b1);
		r = bResp;
		@(posedge core_clk);
		bReady <= 1'b0;
		chk("bresp", 34'(er), 34'(r));
	endtask

	task automatic axiRd(input logic [8:0] idx, input logic [7:0] v, input logic [1:0] er);
		rdExp.push_back({er, 24'h0, v});
		@(posedge core_clk);
		arValid <= 1'b1;
		arAddr  <= {1'b0, idx, 2'b00};
		rReady  <= 1'b1;
		do @(negedge core_clk); while (arReady !== 1'b1);
		@(posedge core_clk);
		arValid <= 1'b0;
		do @(negedge core_clk); while (rValid !== 1'b1);
		@(posedge core_clk);
		rReady <= 1'b0;
	endtask

	//----------------------------------------
	// Link tasks
	//----------------------------------------
	task automatic sendTx(input logic [7:0] n, input logic [7:0] ctl, input logic [7:0] cl, input logic f);
		@(posedge core_clk);
		txFast <= f;
		txHold <= 1'b1;
		axiWr(IDX_REPEAT, n, RESP_OKAY);
		for (int k = 0; k < n; k++)
			for (int i = 0; i < 16; i++)
				txExp.push_back(i == 0 || i == 7 ? 1'b0 : i > 7 ? 1'b1 : w[i-1]);
		for (int i = 0; i < 8; i++)
			txExp.push_back(cl[i]);
		axiWr(IDX_CONTROL, ctl, RESP_OKAY);
		@(posedge core_clk);
		txHold <= 1'b0;
		do @(negedge core_clk); while (fdlTxActive === 1'b1);
		repeat (2) @(negedge core_clk);
		chk("txLeft", 34'h0, 34'(txExp.size()));
	endtask

	task automatic rxSetup(input logic [1:0] rf, input logic [1:0] mf, input logic en);
		axiWr(IDX_CONTROL, 8'h08, RESP_OKAY);
		axiWr(IDX_EXPECT1, {2'h0, w}, RESP_OKAY);
		axiWr(IDX_EXPECT2, {2'h0, w ^ 6'h01}, RESP_OKAY);
		axiWr(IDX_EXPECT3, {2'h0, w}, RESP_OKAY);
		axiWr(IDX_CONTROL, {1'b0, mf, en, 1'b0, rf, 1'b0}, RESP_OKAY);
	endtask

	task automatic rxCheck(input logic r, input logic m);
		repeat (4) @(negedge core_clk);
		chk("rxCodewordAlarm", 34'(r), 34'(rxCodewordAlarm));
		chk("matchAlarm", m ? 34'h5 : 34'h0, 34'(matchAlarm));
	endtask

	//----------------------------------------
	// Monitor and timeout
	//----------------------------------------
	always @(negedge core_clk)
	begin
		if (rValid === 1'b1 && rReady && rdExp.size() > 0)
			chk("rdata", rdExp.pop_front(), {rResp, rData});
		if (slotPrev === 1'b1 && txExp.size() > 0)
			chk("fdlTxBit", 34'(txExp.pop_front()), 34'(fdlTxBit));
	end

	always @(posedge core_clk)
	begin
		slotPrev <= fdlTxSlot;
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fails++;
			test_done();
		end
	end

	//----------------------------------------
	// Main sequence
	//----------------------------------------
	initial
	begin
		{core_clk, awValid, wValid, bReady, arValid, rReady, txHold, txFast, slotPrev} = '0;
		{awAddr, arAddr, wData} = '0;
		wStrb = 4'h1;
		rst = 1'b1;
		fails = 0;
		checksDone = 0;
		cycles = 0;
		void'($urandom(53277));
		w = tssm_word_type'($urandom);
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 11; i++)
			axiRd(IDX_TAB[i], RST_TAB[i], i == 10 ? RESP_SLVERR : RESP_OKAY);
		axiWr(IDX_EXPECT1, {2'h3, w}, RESP_OKAY);
		axiRd(IDX_EXPECT1, {2'h0, w}, RESP_OKAY);
		axiWr(9'h100, 8'h55, RESP_SLVERR);
		axiWr(IDX_TXWORD, {2'h0, w}, RESP_OKAY);
		wStrb <= 4'h0;
		axiWr(IDX_TXWORD, 8'h3f ^ {2'h0, w}, RESP_OKAY);
		wStrb <= 4'h1;
		axiRd(IDX_TXWORD, {2'h0, w}, RESP_OKAY);
		sendTx(8'h02, 8'h01, IDLE_FLAG, 1'b0);
		axiRd(IDX_CONTROL, 8'h00, RESP_OKAY);
		sendTx(8'h01, 8'h81, ABORT_SEQ, 1'b1);
		axiWr(IDX_REPEAT, 8'h00, RESP_OKAY);
		axiWr(IDX_CONTROL, 8'h01, RESP_OKAY);
		repeat (200) @(negedge core_clk);
		chk("fdlTxActive", 34'h1, 34'(fdlTxActive));
		sendTx(8'h01, 8'h01, IDLE_FLAG, 1'b0);
		for (int f = 0; f < 4; f++)
		begin
			rxSetup(2'(f), 2'(3 - f), 1'b1);
			for (int k = 1; k <= 7; k++)
			begin
				i_far.sendFrame(w, 1'b0);
				rxCheck(k >= 2 * f + 1, k >= 7 - 2 * f);
			end
		end
		rxSetup(2'h1, 2'h1, 1'b0);
		repeat (3) i_far.sendFrame(w, 1'b0);
		rxCheck(1'b0, 1'b0);
		rxSetup(2'h1, 2'h1, 1'b1);
		for (int k = 0; k < 5; k++)
			i_far.sendFrame(w, k == 2);
		rxCheck(1'b0, 1'b0);
		i_far.sendFrame(w, 1'b0);
		rxCheck(1'b1, 1'b1);
		axiRd(IDX_RXWORD, {2'h0, w}, RESP_OKAY);
		axiWr(IDX_STATUS, 8'h0f, RESP_OKAY);
		rxCheck(1'b0, 1'b0);
		axiWr(IDX_CONTROL, 8'h08, RESP_OKAY);
		for (int i = 0; i < 8; i++)
			axiRd(IDX_TAB[i], RST_TAB[i], RESP_OKAY);
		test_done();
	end
endmodule // tssm_codeword_link_tb

/* sim/tssm_far_end.sv */
// Far-end terminal model: transmit bit slots and received codeword frames
module tssm_far_end
	import tssm_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic txHold,
	input  wire logic txFast,
	input  wire logic fdlTxActive,
	output      logic fdlTxSlot,
	output      logic fdlRxSlot,
	output      logic fdlRxBit
);
	timeunit 1ns;
	timeprecision 1ns;

	// Slots only while a frame is on the line, every cycle or every other
	always_ff @(posedge core_clk)
	begin
		fdlTxSlot <= !rst && !txHold && fdlTxActive && (txFast || !fdlTxSlot);
	end

	initial
	begin
		fdlRxSlot = 1'b0;
		fdlRxBit  = 1'b1;
	end

	// Line shows the inverse bit between slots
	task automatic sendFrame(input tssm_word_type w, input logic bad);
		logic [15:0] f;
		f = {8'hff, 1'b0, w, 1'b0};
		if (bad)
			f[12] = 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			@(posedge core_clk);
			fdlRxSlot <= 1'b1;
			fdlRxBit  <= f[i];
			@(posedge core_clk);
			fdlRxSlot <= 1'b0;
			fdlRxBit  <= ~f[i];
		end
	endtask
endmodule // tssm_far_end
